// *** logic/scrb_pkg.sv ***
// scrb_pkg: offsets, reset values and field positions of the system control register bank
// assumes a 16-bit internal bus with a byte address relative to the peripheral base or absolute for the scr
package scrb_pkg;
  localparam logic [11:0] OFF_SCR_HI = 12'h0f4;
  localparam logic [11:0] OFF_SCR_LO = 12'h0f6;
  localparam logic [11:0] OFF_TMR2_EVT = 12'h859;
  localparam logic [11:0] OFF_CP_CMD = 12'h860;
  localparam logic [11:0] OFF_S1_CFG = 12'h882;
  localparam logic [11:0] OFF_S1_MODE = 12'h884;
  localparam logic [11:0] OFF_S1_SYNC = 12'h886;
  localparam logic [11:0] OFF_S1_EVT = 12'h888;
  localparam logic [11:0] OFF_S1_MASK = 12'h88a;
  localparam logic [11:0] OFF_S1_STAT = 12'h88c;
  localparam logic [11:0] OFF_S2_CFG = 12'h892;
  localparam logic [11:0] OFF_S2_MODE = 12'h894;
  localparam logic [11:0] OFF_S2_SYNC = 12'h896;
  localparam logic [11:0] OFF_S2_EVT = 12'h898;
  localparam logic [11:0] OFF_S2_MASK = 12'h89a;
  localparam logic [11:0] OFF_S2_STAT = 12'h89c;
  localparam logic [11:0] OFF_AUX_MODE = 12'h8b0;
  localparam logic [11:0] OFF_SI_MASK = 12'h8b2;
  localparam logic [11:0] OFF_SI_MODE = 12'h8b4;
  localparam logic [11:0] OFF_PIN_DIR = 12'h8dc;
  localparam logic [11:0] OFF_PIN_VAL = 12'h8de;
  localparam logic [11:0] OFF_S1_CLKDIS = 12'h8ee;
  localparam logic [2:0] FC_SUPER_DATA = 3'h5;
  localparam logic [15:0] RST_CFG = 16'h0004;
  localparam logic [15:0] RST_S1_MODE = 16'h0004;
  localparam logic [15:0] RST_SYNC = 16'h7e7e;
  localparam logic [15:0] RST_SI_MASK = 16'hffff;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  // scr control byte 23..16 and low byte 15..8 after reset: only bus watchdog enable (bit 11) set
  localparam logic [7:0] RST_SCR_CTL = 8'h00;
  localparam logic [7:0] RST_SCR_LOW = 8'h08;
  localparam int BIT_WDOG_EN = 11;
  localparam int BIT_VECGEN = 21;
endpackage

// *** logic/scrb_w1c.sv ***
// scrb_w1c: W event flags (a byte by default) set by hardware, cleared by writing one
// assumes set pulses on clk_sys; set wins over a same-cycle clear
`timescale 1ns/1ps
`default_nettype none
module scrb_w1c #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic clr_rst,
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] clr_mask,
  output logic [W-1:0] flags
);
  logic [W-1:0] flags_r;
  wire logic [W-1:0] flags_nxt = (flags_r & ~clr_mask) | set_evt;
  assign flags = flags_r;
  always_ff @(posedge clk_sys) begin
    if (clr_rst) flags_r <= '0;
    else flags_r <= flags_nxt;
  end
  AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (clr_rst)
    (set_evt != '0) |=> ((flags_r & $past(set_evt)) == $past(set_evt)))
    else $error("event lost against clear");
endmodule
`default_nettype wire

// *** logic/scrb_bank.sv ***
// scrb_bank: system control register and upper peripheral register block
// assumes a single-cycle internal bus on clk_sys: request valid one cycle, read data next cycle
// Behaviour
// - scr at 0f4, supervisor data only
// - scr bits 31..28 zero, 27..24 status
// - bits 23..16 control enables in order
// - bits 15..8 freezes, sam, wdog enable, count
// - total-reset-only registers keep value on soft reset
// - pin data latch undefined after total reset (this bank clears it to 00)
// - event registers flag hardware events
// - sync pattern 7e7e, configuration 0004
// - si mask ffff, si mode 0000
// - aux serial mode/clock resets to 0000
// - ch1 clock disable 0000, total reset only
// - write one clears status, zero keeps
// - status flags clear on total reset
// - wdog enable resets one, others zero
`timescale 1ns/1ps
`default_nettype none
module scrb_bank
  import scrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_total,
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [11:0] bus_addr,
  input wire logic [2:0] bus_fc,
  input wire logic [1:0] bus_be,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  input wire logic [3:0] sys_status_evt,
  input wire logic [7:0] tmr2_evt,
  input wire logic [7:0] s1_evt,
  input wire logic [15:0] s2_evt,
  input wire logic [7:0] s1_line,
  input wire logic [7:0] s2_line,
  output logic [7:0] scr_control,
  output logic [7:0] scr_low,
  output logic [7:0] cp_command,
  output logic [15:0] s1_cfg,
  output logic [15:0] s1_mode,
  output logic [15:0] s1_sync,
  output logic [7:0] s1_mask,
  output logic [15:0] s2_cfg,
  output logic [15:0] s2_mode,
  output logic [15:0] s2_sync,
  output logic [7:0] s2_mask,
  output logic [15:0] aux_mode,
  output logic [15:0] si_mask,
  output logic [15:0] si_mode,
  output logic [7:0] pin_dir,
  output logic [7:0] pin_val,
  output logic [15:0] s1_clkdis
);
  // any reset loads ordinary registers with their reset values; total-reset-only ones watch rst_total alone
  wire logic any_rst = rst | rst_total;
  function automatic logic [15:0] lane_merge(input logic [15:0] cur, input logic [15:0] wd, input logic [1:0] be);
    lane_merge = {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
  endfunction

  // scr is only seen in supervisor data space
  wire logic sup = bus_fc == FC_SUPER_DATA;
  wire logic [11:0] wa = {bus_addr[11:1], 1'b0};
  wire logic wr = bus_req & bus_wr;
  wire logic hit_scr_hi = sup & (wa == OFF_SCR_HI);
  wire logic hit_scr_lo = sup & (wa == OFF_SCR_LO);
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = a == {off[11:1], 1'b0};
  endfunction
  wire logic w_scr_hi = wr & hit_scr_hi;
  wire logic w_scr_lo = wr & hit_scr_lo;

  logic [3:0] status_r;
  logic [7:0] scr_ctl_r;
  logic [7:0] scr_low_r;
  logic [7:0] cp_r;
  logic [7:0] s1_mask_r;
  logic [7:0] s2_mask_r;
  logic [7:0] pin_dir_r;
  logic [7:0] pin_val_r;
  logic [15:0] s1_cfg_r;
  logic [15:0] s1_mode_r;
  logic [15:0] s1_sync_r;
  logic [15:0] s2_cfg_r;
  logic [15:0] s2_mode_r;
  logic [15:0] s2_sync_r;
  logic [15:0] aux_r;
  logic [15:0] si_mask_r;
  logic [15:0] si_mode_r;
  logic [15:0] s1_clkdis_r;
  logic [15:0] rdata_r;
  logic ack_r;

  // status sits in the even byte at 0f4, so its clear follows the high lane; event wins over clear
  wire logic [3:0] status_clr = (w_scr_hi & bus_be[1]) ? bus_wdata[11:8] : 4'h0;
  wire logic [3:0] status_nxt = (status_r & ~status_clr) | sys_status_evt;
  always_ff @(posedge clk_sys) begin
    if (rst_total) status_r <= 4'h0;
    else status_r <= status_nxt;
  end

  // hi word: [15:8]=bits 31..24, [7:0]=bits 23..16 (odd byte, low lane)
  // lo word: [15:8]=bits 15..8; its low byte is unused and reads zero
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      scr_ctl_r <= RST_SCR_CTL;
      scr_low_r <= RST_SCR_LOW;
    end else begin
      if (w_scr_hi & bus_be[0]) scr_ctl_r <= bus_wdata[7:0];
      if (w_scr_lo & bus_be[1]) scr_low_r <= bus_wdata[15:8];
    end
  end

  wire logic [7:0] t2_clr = (wr & hit(wa, OFF_TMR2_EVT) & bus_be[0]) ? bus_wdata[7:0] : 8'h00;
  wire logic [7:0] s1e_clr = (wr & hit(wa, OFF_S1_EVT) & bus_be[1]) ? bus_wdata[15:8] : 8'h00;
  wire logic [15:0] s2e_clr = (wr & hit(wa, OFF_S2_EVT)) ? {bus_be[1] ? bus_wdata[15:8] : 8'h00,
    bus_be[0] ? bus_wdata[7:0] : 8'h00} : 16'h0000;
  logic [7:0] t2_flags, s1_flags;
  logic [15:0] s2_flags;
  scrb_w1c #(.W(8)) u_t2 (.clk_sys(clk_sys), .clr_rst(any_rst), .set_evt(tmr2_evt), .clr_mask(t2_clr),
    .flags(t2_flags));
  scrb_w1c #(.W(8)) u_s1 (.clk_sys(clk_sys), .clr_rst(any_rst), .set_evt(s1_evt), .clr_mask(s1e_clr),
    .flags(s1_flags));
  scrb_w1c #(.W(16)) u_s2 (.clk_sys(clk_sys), .clr_rst(any_rst), .set_evt(s2_evt), .clr_mask(s2e_clr),
    .flags(s2_flags));

  wire logic w_cp = wr & hit(wa, OFF_CP_CMD) & bus_be[1];
  wire logic w_s1m = wr & hit(wa, OFF_S1_MASK) & bus_be[1];
  wire logic w_s2m = wr & hit(wa, OFF_S2_MASK) & bus_be[1];
  // 8-bit pin registers at even offsets sit in the high lane
  wire logic w_pdir = wr & hit(wa, OFF_PIN_DIR) & bus_be[1];
  wire logic w_pval = wr & hit(wa, OFF_PIN_VAL) & bus_be[1];
  // word registers take each enabled lane on its own
  wire logic w_s1cfg = wr & hit(wa, OFF_S1_CFG);
  wire logic w_s1mode = wr & hit(wa, OFF_S1_MODE);
  wire logic w_s1sync = wr & hit(wa, OFF_S1_SYNC);
  wire logic w_s2cfg = wr & hit(wa, OFF_S2_CFG);
  wire logic w_s2mode = wr & hit(wa, OFF_S2_MODE);
  wire logic w_s2sync = wr & hit(wa, OFF_S2_SYNC);
  wire logic w_aux = wr & hit(wa, OFF_AUX_MODE);
  wire logic w_serial_iface_mask = wr & hit(wa, OFF_SI_MASK);
  wire logic w_serial_iface_mode = wr & hit(wa, OFF_SI_MODE);
  wire logic w_clkdis = wr & hit(wa, OFF_S1_CLKDIS);

  // ordinary registers, loaded with their reset values by either reset
  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      cp_r <= RST_ZERO8;
      s1_cfg_r <= RST_CFG;
      s1_mode_r <= RST_S1_MODE;
      s1_sync_r <= RST_SYNC;
      s1_mask_r <= RST_ZERO8;
      s2_cfg_r <= RST_CFG;
      s2_mode_r <= RST_ZERO16;
      s2_sync_r <= RST_SYNC;
      s2_mask_r <= RST_ZERO8;
      aux_r <= RST_ZERO16;
    end else begin
      if (w_cp) cp_r <= bus_wdata[15:8];
      if (w_s1cfg) s1_cfg_r <= lane_merge(s1_cfg_r, bus_wdata, bus_be);
      if (w_s1mode) s1_mode_r <= lane_merge(s1_mode_r, bus_wdata, bus_be);
      if (w_s1sync) s1_sync_r <= lane_merge(s1_sync_r, bus_wdata, bus_be);
      if (w_s1m) s1_mask_r <= bus_wdata[15:8];
      if (w_s2cfg) s2_cfg_r <= lane_merge(s2_cfg_r, bus_wdata, bus_be);
      if (w_s2mode) s2_mode_r <= lane_merge(s2_mode_r, bus_wdata, bus_be);
      if (w_s2sync) s2_sync_r <= lane_merge(s2_sync_r, bus_wdata, bus_be);
      if (w_s2m) s2_mask_r <= bus_wdata[15:8];
      if (w_aux) aux_r <= lane_merge(aux_r, bus_wdata, bus_be);
    end
  end

  // total-reset-only registers survive the soft reset instruction
  always_ff @(posedge clk_sys) begin
    if (rst_total) begin
      si_mask_r <= RST_SI_MASK;
      si_mode_r <= RST_ZERO16;
      pin_dir_r <= RST_ZERO8;
      s1_clkdis_r <= RST_ZERO16;
    end else begin
      if (w_serial_iface_mask) si_mask_r <= lane_merge(si_mask_r, bus_wdata, bus_be);
      if (w_serial_iface_mode) si_mode_r <= lane_merge(si_mode_r, bus_wdata, bus_be);
      if (w_pdir) pin_dir_r <= bus_wdata[15:8];
      if (w_clkdis) s1_clkdis_r <= lane_merge(s1_clkdis_r, bus_wdata, bus_be);
    end
  end

  // data latch cleared anyway so outputs are defined; software must not rely on it
  always_ff @(posedge clk_sys) begin
    if (rst_total) pin_val_r <= RST_ZERO8;
    else if (w_pval) pin_val_r <= bus_wdata[15:8];
  end

  // read mux; anything not decoded reads zero and ack still comes
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_scr_hi) rd_mux = {4'h0, status_r, scr_ctl_r};
    else if (hit_scr_lo) rd_mux = {scr_low_r, 8'h00};
    else if (hit(wa, OFF_TMR2_EVT)) rd_mux = {8'h00, t2_flags};
    else if (hit(wa, OFF_CP_CMD)) rd_mux = {cp_r, 8'h00};
    else if (hit(wa, OFF_S1_CFG)) rd_mux = s1_cfg_r;
    else if (hit(wa, OFF_S1_MODE)) rd_mux = s1_mode_r;
    else if (hit(wa, OFF_S1_SYNC)) rd_mux = s1_sync_r;
    else if (hit(wa, OFF_S1_EVT)) rd_mux = {s1_flags, 8'h00};
    else if (hit(wa, OFF_S1_MASK)) rd_mux = {s1_mask_r, 8'h00};
    else if (hit(wa, OFF_S1_STAT)) rd_mux = {s1_line, 8'h00};
    else if (hit(wa, OFF_S2_CFG)) rd_mux = s2_cfg_r;
    else if (hit(wa, OFF_S2_MODE)) rd_mux = s2_mode_r;
    else if (hit(wa, OFF_S2_SYNC)) rd_mux = s2_sync_r;
    else if (hit(wa, OFF_S2_EVT)) rd_mux = s2_flags;
    else if (hit(wa, OFF_S2_MASK)) rd_mux = {s2_mask_r, 8'h00};
    else if (hit(wa, OFF_S2_STAT)) rd_mux = {s2_line, 8'h00};
    else if (hit(wa, OFF_AUX_MODE)) rd_mux = aux_r;
    else if (hit(wa, OFF_SI_MASK)) rd_mux = si_mask_r;
    else if (hit(wa, OFF_SI_MODE)) rd_mux = si_mode_r;
    else if (hit(wa, OFF_PIN_DIR)) rd_mux = {pin_dir_r, 8'h00};
    else if (hit(wa, OFF_PIN_VAL)) rd_mux = {pin_val_r, 8'h00};
    else if (hit(wa, OFF_S1_CLKDIS)) rd_mux = s1_clkdis_r;
  end

  always_ff @(posedge clk_sys) begin
    if (any_rst) begin
      rdata_r <= RST_ZERO16;
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
      if (bus_req & ~bus_wr) rdata_r <= rd_mux;
    end
  end

  assign bus_rdata = rdata_r;
  assign bus_ack = ack_r;
  assign scr_control = scr_ctl_r;
  assign scr_low = scr_low_r;
  assign cp_command = cp_r;
  assign s1_cfg = s1_cfg_r;
  assign s1_mode = s1_mode_r;
  assign s1_sync = s1_sync_r;
  assign s1_mask = s1_mask_r;
  assign s2_cfg = s2_cfg_r;
  assign s2_mode = s2_mode_r;
  assign s2_sync = s2_sync_r;
  assign s2_mask = s2_mask_r;
  assign aux_mode = aux_r;
  assign si_mask = si_mask_r;
  assign si_mode = si_mode_r;
  assign pin_dir = pin_dir_r;
  assign pin_val = pin_val_r;
  assign s1_clkdis = s1_clkdis_r;

  AST_SCR_READ_HI: assert property (@(posedge clk_sys) disable iff (any_rst)
    (bus_req & ~bus_wr & hit_scr_hi) |=> (bus_rdata[15:12] == 4'h0 && bus_rdata[11:8] == $past(status_r)))
    else $error("scr high read wrong");
  AST_SCR_FC: assert property (@(posedge clk_sys) disable iff (any_rst)
    (bus_req & ~bus_wr & (bus_fc != FC_SUPER_DATA) & (wa == OFF_SCR_HI)) |=> (bus_rdata == 16'h0000))
    else $error("scr visible outside supervisor data");
  AST_STATUS_W1C: assert property (@(posedge clk_sys) disable iff (rst_total)
    (w_scr_hi & bus_be[1] & (sys_status_evt == 4'h0)) |=> ((status_r & $past(bus_wdata[11:8])) == 4'h0))
    else $error("status flag not cleared by one");
  AST_STATUS_KEEP: assert property (@(posedge clk_sys) disable iff (rst_total)
    (w_scr_hi & bus_be[1]) |=> ((status_r & ~$past(bus_wdata[11:8])) == ($past(status_r) & ~$past(bus_wdata[11:8]))
    || (sys_status_evt != 4'h0) || ($past(sys_status_evt) != 4'h0)))
    else $error("status flag changed by zero");
  AST_TOTAL_RST: assert property (@(posedge clk_sys) rst_total |=> (status_r == 4'h0 && si_mask == RST_SI_MASK
    && s1_clkdis == RST_ZERO16 && si_mode == RST_ZERO16))
    else $error("total reset values wrong");
  AST_SOFT_KEEP: assert property (@(posedge clk_sys) (rst & ~rst_total & ~$past(rst_total)) |=>
    (si_mask == $past(si_mask) && s1_clkdis == $past(s1_clkdis) && pin_dir == $past(pin_dir)))
    else $error("soft reset touched total-reset register");
  AST_RST_VALUES: assert property (@(posedge clk_sys) any_rst |=> (scr_low[BIT_WDOG_EN-8] && s1_sync == RST_SYNC
    && s2_sync == RST_SYNC && s1_cfg == RST_CFG && s2_cfg == RST_CFG && aux_mode == RST_ZERO16
    && scr_control == RST_SCR_CTL))
    else $error("reset values wrong");
  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (any_rst)
    (bus_req & ~bus_wr & (wa == 12'h8a0)) |=> (bus_ack && bus_rdata == 16'h0000))
    else $error("reserved slot not zero");
  AST_LOW_LANE: assert property (@(posedge clk_sys) disable iff (any_rst)
    (wr & hit(wa, OFF_PIN_DIR) & ~bus_be[1]) |=> (pin_dir == $past(pin_dir)))
    else $error("pin direction written from wrong lane");
  // handshake: every request is answered once, one cycle later, mapped or not
  AST_ACK_NEXT: assert property (@(posedge clk_sys) disable iff (any_rst)
    bus_req |=> bus_ack)
    else $error("request not acknowledged");
  AST_ACK_ONLY: assert property (@(posedge clk_sys) disable iff (any_rst)
    !bus_req |=> !bus_ack)
    else $error("acknowledge without request");
  AST_RDATA_HOLD: assert property (@(posedge clk_sys) disable iff (any_rst)
    (!bus_req || bus_wr) |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  AST_SCR_LO_READ: assert property (@(posedge clk_sys) disable iff (any_rst)
    (bus_req & ~bus_wr & hit_scr_lo) |=> (bus_rdata == {$past(scr_low), 8'h00}))
    else $error("scr low read wrong");
  AST_SCR_CTL_WR: assert property (@(posedge clk_sys) disable iff (any_rst)
    (w_scr_hi & bus_be[0]) |=> (scr_control == $past(bus_wdata[7:0])))
    else $error("scr control byte not written");
  AST_SCR_LO_WR: assert property (@(posedge clk_sys) disable iff (any_rst)
    (w_scr_lo & bus_be[1]) |=> (scr_low == $past(bus_wdata[15:8])))
    else $error("scr low byte not written");
  AST_SCR_NONSUP: assert property (@(posedge clk_sys) disable iff (any_rst)
    (wr & ~sup & (wa == OFF_SCR_HI)) |=> (scr_control == $past(scr_control)))
    else $error("scr written outside supervisor data");
  AST_STATUS_SET: assert property (@(posedge clk_sys) disable iff (rst_total)
    (sys_status_evt != 4'h0) |=> ((status_r & $past(sys_status_evt)) == $past(sys_status_evt)))
    else $error("status event lost");
  AST_EVT_SET: assert property (@(posedge clk_sys) disable iff (any_rst)
    (tmr2_evt != 8'h00 || s1_evt != 8'h00) |=> ((t2_flags & $past(tmr2_evt)) == $past(tmr2_evt)
    && (s1_flags & $past(s1_evt)) == $past(s1_evt)))
    else $error("event flag not set");
  AST_S2_CLEAR: assert property (@(posedge clk_sys) disable iff (any_rst)
    (wr & hit(wa, OFF_S2_EVT) & (bus_be == 2'b11) & (s2_evt == 16'h0000)) |=> ((s2_flags & $past(bus_wdata)) == 16'h0000))
    else $error("channel 2 event not cleared");
  AST_T2_LANE: assert property (@(posedge clk_sys) disable iff (any_rst)
    (wr & hit(wa, OFF_TMR2_EVT) & ~bus_be[0]) |=> (t2_flags == ($past(t2_flags) | $past(tmr2_evt))))
    else $error("timer event cleared from wrong lane");
  AST_CP_WR: assert property (@(posedge clk_sys) disable iff (any_rst)
    w_cp |=> (cp_command == $past(bus_wdata[15:8])))
    else $error("command byte not written from high lane");
  AST_AUX_LANE: assert property (@(posedge clk_sys) disable iff (any_rst)
    (w_aux & (bus_be == 2'b01)) |=> (aux_mode[15:8] == $past(aux_mode[15:8])
    && aux_mode[7:0] == $past(bus_wdata[7:0])))
    else $error("aux mode lane write wrong");
  AST_MODE_RST: assert property (@(posedge clk_sys) any_rst |=> (s1_mode == RST_S1_MODE
    && s2_mode == RST_ZERO16 && cp_command == RST_ZERO8 && s1_mask == RST_ZERO8
    && s2_mask == RST_ZERO8))
    else $error("mode or mask reset value wrong");
  AST_PIN_RST: assert property (@(posedge clk_sys)
    rst_total |=> (pin_dir == RST_ZERO8 && pin_val == RST_ZERO8))
    else $error("pin registers not cleared by total reset");
  AST_CLKDIS_WR: assert property (@(posedge clk_sys) disable iff (rst_total)
    (w_clkdis & (bus_be == 2'b11)) |=> (s1_clkdis == $past(bus_wdata)))
    else $error("clock disable not written");
  AST_SI_WR: assert property (@(posedge clk_sys) disable iff (rst_total)
    (w_serial_iface_mask & (bus_be == 2'b11)) |=> (si_mask == $past(bus_wdata)))
    else $error("serial iface mask not written");
  AST_RSVD_WR: assert property (@(posedge clk_sys) disable iff (any_rst)
    (wr & (wa == 12'h8a0)) |=> (s2_sync == $past(s2_sync) && aux_mode == $past(aux_mode)))
    else $error("reserved write reached a register");
  AST_EVT_RST: assert property (@(posedge clk_sys)
    any_rst |=> (t2_flags == RST_ZERO8 && s1_flags == RST_ZERO8 && s2_flags == RST_ZERO16))
    else $error("event flags not cleared by reset");
endmodule
`default_nettype wire

// *** test/scrb_cpu_model.sv ***
// scrb_cpu_model: processor core issuing single accesses on the internal bus
// assumes the bank takes a one-cycle request and acks exactly one cycle later
`timescale 1ns/1ps
`default_nettype none
module scrb_cpu_model (
  input wire logic clk_sys,
  output logic bus_req,
  output logic bus_wr,
  output logic [11:0] bus_addr,
  output logic [2:0] bus_fc,
  output logic [1:0] bus_be,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);
  initial begin
    bus_req = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 12'h000;
    bus_fc = 3'h5;
    bus_be = 2'b00;
    bus_wdata = 16'h0000;
  end
  // lanes not enabled carry junk, as a real core would leave them
  task automatic access(input logic w, input logic [11:0] a, input logic [2:0] f, input logic [1:0] b,
                        input logic [15:0] d, output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk_sys);
    bus_req <= 1'b1;
    bus_wr <= w;
    bus_addr <= a;
    bus_fc <= f;
    bus_be <= b;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_req <= 1'b0;
    // released address and data show the inverse, so a stale value never passes
    bus_addr <= ~a;
    bus_wdata <= ~d;
    n = 0;
    ok = 1'b0;
    while (n < 4 && ok !== 1'b1) begin
      @(posedge clk_sys);
      ok = bus_ack;
      q = bus_rdata;
      n++;
    end
  endtask
endmodule
`default_nettype wire

// *** test/system_control_register_bank_tb.sv ***
// system_control_register_bank_tb: bank against an integer model of every mapped word
// assumes the partner model owns the bus; events and line status are driven here
`timescale 1ns/1ps
`default_nettype none
module system_control_register_bank_tb;
  import scrb_pkg::*;
  logic clk_sys, rst, rst_total, bus_req, bus_wr, bus_ack;
  logic [11:0] bus_addr;
  logic [2:0] bus_fc;
  logic [1:0] bus_be;
  logic [15:0] bus_wdata, bus_rdata, s2_evt;
  logic [3:0] sys_status_evt;
  logic [7:0] tmr2_evt, s1_evt, s1_line, s2_line;
  logic [7:0] scr_control, scr_low, cp_command, s1_mask, s2_mask, pin_dir, pin_val;
  logic [15:0] s1_cfg, s1_mode, s1_sync, s2_cfg, s2_mode, s2_sync, aux_mode, si_mask, si_mode, s1_clkdis;
  int errors, tests_run, mdl[int];
  logic [31:0] seed;
  logic pin_undef;
  logic [11:0] al[$] = '{12'h0f4, 12'h0f6, 12'h859, 12'h860, 12'h882, 12'h884, 12'h886, 12'h888, 12'h88a,
    12'h88c, 12'h892, 12'h894, 12'h896, 12'h898, 12'h89a, 12'h89c, 12'h8b0, 12'h8b2, 12'h8b4, 12'h8dc,
    12'h8de, 12'h8ee, 12'h85a, 12'h880, 12'h8a0, 12'h8f0};
  scrb_cpu_model cpu_u (.clk_sys(clk_sys), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_fc(bus_fc), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));
  scrb_bank dut_u (.clk_sys(clk_sys), .rst(rst), .rst_total(rst_total), .bus_req(bus_req), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_fc(bus_fc), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .sys_status_evt(sys_status_evt), .tmr2_evt(tmr2_evt), .s1_evt(s1_evt),
    .s2_evt(s2_evt), .s1_line(s1_line), .s2_line(s2_line), .scr_control(scr_control), .scr_low(scr_low),
    .cp_command(cp_command), .s1_cfg(s1_cfg), .s1_mode(s1_mode), .s1_sync(s1_sync), .s1_mask(s1_mask),
    .s2_cfg(s2_cfg), .s2_mode(s2_mode), .s2_sync(s2_sync), .s2_mask(s2_mask), .aux_mode(aux_mode),
    .si_mask(si_mask), .si_mode(si_mode), .pin_dir(pin_dir), .pin_val(pin_val), .s1_clkdis(s1_clkdis));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic int rwm(input int a);
    case (a)
      'h0f4: return 'h00ff;
      'h0f6, 'h860, 'h88a, 'h89a, 'h8dc, 'h8de: return 'hff00;
      'h882, 'h884, 'h886, 'h892, 'h894, 'h896, 'h8b0, 'h8b2, 'h8b4, 'h8ee: return 'hffff;
      default: return 0;
    endcase
  endfunction
  function automatic int w1m(input int a);
    case (a)
      'h0f4: return 'h0f00;
      'h859: return 'h00ff;
      'h888: return 'hff00;
      'h898: return 'hffff;
      default: return 0;
    endcase
  endfunction
  function automatic int rv(input int a);
    case (a)
      'h882, 'h884, 'h892: return 'h0004;
      'h886, 'h896: return 'h7e7e;
      'h8b2: return 'hffff;
      'h0f6: return 'h0800;
      'h88c: return {s1_line, 8'h00};
      'h89c: return {s2_line, 8'h00};
      default: return 0;
    endcase
  endfunction
  task automatic do_reset(input logic total);
    @(posedge clk_sys);
    rst <= ~total;
    rst_total <= total;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rst_total <= 1'b0;
    // registers kept over a soft reset: serial iface, pin io, ch1 clock disable, status
    foreach (al[i]) begin
      if (total || !(al[i] inside {12'h8b2, 12'h8b4, 12'h8dc, 12'h8de, 12'h8ee}))
        mdl[al[i]] = (al[i] == 12'h0f4 && !total) ? (mdl[al[i]] & 'h0f00) : rv(al[i]);
    end
    if (total)
      pin_undef = 1'b1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [2:0] f, input logic [1:0] b, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    int m;
    if (a == 12'h0f4)
      d[5] = 1'b0;
    cpu_u.access(1'b1, a, f, b, d, q, ok);
    m = {b[1] ? 8'hff : 8'h00, b[0] ? 8'hff : 8'h00};
    if (a[11:8] == 4'h0 && f != FC_SUPER_DATA)
      m = 0;
    mdl[a] = (mdl[a] & ~(rwm(a) & m)) | (d & rwm(a) & m);
    mdl[a] = mdl[a] & ~(d & w1m(a) & m);
    if (a == 12'h8de && b[1])
      pin_undef = 1'b0;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t no ack on write to %h", $time, a);
    end
  endtask
  task automatic chk(input logic [11:0] a, input logic [2:0] f);
    logic [15:0] q, e;
    logic ok;
    cpu_u.access(1'b0, a, f, 2'b11, 16'h0000, q, ok);
    e = (a[11:8] == 4'h0 && f != FC_SUPER_DATA) ? 16'h0000 : 16'(mdl[a]);
    tests_run++;
    if (!(a == 12'h8de && pin_undef) && (ok !== 1'b1 || q !== e)) begin
      errors++;
      $display("MISMATCH t=%0t read %h got %h expected %h", $time, a, q, e);
    end
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [11:0] a);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t output for %h is %h expected %h", $time, a, got, exp);
    end
  endtask
  // register outputs must agree with what the bus reads back
  task automatic chkout();
    cmp({8'h00, scr_control}, 16'(mdl[12'h0f4] & 'h00ff), 12'h0f4);
    cmp({scr_low, 8'h00}, 16'(mdl[12'h0f6]), 12'h0f6);
    cmp({cp_command, 8'h00}, 16'(mdl[12'h860]), 12'h860);
    cmp(s1_cfg, 16'(mdl[12'h882]), 12'h882);
    cmp(s1_mode, 16'(mdl[12'h884]), 12'h884);
    cmp(s1_sync, 16'(mdl[12'h886]), 12'h886);
    cmp({s1_mask, 8'h00}, 16'(mdl[12'h88a]), 12'h88a);
    cmp(s2_cfg, 16'(mdl[12'h892]), 12'h892);
    cmp(s2_mode, 16'(mdl[12'h894]), 12'h894);
    cmp(s2_sync, 16'(mdl[12'h896]), 12'h896);
    cmp({s2_mask, 8'h00}, 16'(mdl[12'h89a]), 12'h89a);
    cmp(aux_mode, 16'(mdl[12'h8b0]), 12'h8b0);
    cmp(si_mask, 16'(mdl[12'h8b2]), 12'h8b2);
    cmp(si_mode, 16'(mdl[12'h8b4]), 12'h8b4);
    cmp({pin_dir, 8'h00}, 16'(mdl[12'h8dc]), 12'h8dc);
    cmp(s1_clkdis, 16'(mdl[12'h8ee]), 12'h8ee);
    if (!pin_undef)
      cmp({pin_val, 8'h00}, 16'(mdl[12'h8de]), 12'h8de);
  endtask
  task automatic chkall();
    foreach (al[i]) chk(al[i], FC_SUPER_DATA);
    chkout();
  endtask
  task automatic pulse(input logic [3:0] st, input logic [7:0] t2, input logic [7:0] e1, input logic [15:0] e2);
    @(posedge clk_sys);
    sys_status_evt <= st;
    tmr2_evt <= t2;
    s1_evt <= e1;
    s2_evt <= e2;
    @(posedge clk_sys);
    sys_status_evt <= 4'h0;
    tmr2_evt <= 8'h00;
    s1_evt <= 8'h00;
    s2_evt <= 16'h0000;
    mdl[12'h0f4] = mdl[12'h0f4] | {st, 8'h00};
    mdl[12'h859] = mdl[12'h859] | t2;
    mdl[12'h888] = mdl[12'h888] | {e1, 8'h00};
    mdl[12'h898] = mdl[12'h898] | e2;
  endtask
  task automatic report_and_stop();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial begin
    seed = 32'h24295737;
    errors = 0;
    tests_run = 0;
    rst = 1'b0;
    rst_total = 1'b0;
    sys_status_evt = 4'h0;
    tmr2_evt = 8'h00;
    s1_evt = 8'h00;
    s2_evt = 16'h0000;
    s1_line = 8'($random(seed));
    s2_line = 8'($random(seed));
    do_reset(1'b1);
    chkall();
    // random lanes over every slot, reserved and read-only ones included
    repeat (4) foreach (al[i]) wr(al[i], FC_SUPER_DATA, 2'($random(seed)), 16'($random(seed)));
    chkall();
    wr(12'h0f4, 3'h1, 2'b11, 16'h00df);
    chk(12'h0f4, 3'h1);
    chk(12'h0f4, FC_SUPER_DATA);
    pulse(4'hf, 8'h81, 8'h42, 16'h8001);
    chkall();
    wr(12'h0f4, FC_SUPER_DATA, 2'b11, 16'(mdl[12'h0f4] & 'h00ff) | 16'h0500);
    wr(12'h859, FC_SUPER_DATA, 2'b01, 16'h0080);
    wr(12'h898, FC_SUPER_DATA, 2'b11, 16'h8000);
    chkall();
    wr(12'h8de, FC_SUPER_DATA, 2'b10, 16'ha500);
    do_reset(1'b0);
    chkall();
    do_reset(1'b1);
    chkall();
    report_and_stop();
  end
endmodule
`default_nettype wire
